// ### hdl/mwd_cfg.svh
// Offsets, field positions, reset values and timing counts of the mode and watchdog link
`ifndef MWD_CFG_SVH
`define MWD_CFG_SVH

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define MWD_FRAME_BITS    5'd16
`define MWD_ADDR_MODE     2'h0
`define MWD_F_ADDR        15:14
`define MWD_B_PAGE        13
`define MWD_B_RDONLY      12
`define MWD_F_PERIOD      11:6
`define MWD_F_STATE       5:3
`define MWD_B_RELAX       2
`define MWD_B_EN          1
`define MWD_B_RSV         0

// ----------------------------------------------------------------
// Reset-cause codes and reset values
// ----------------------------------------------------------------
`define MWD_CAUSE_POR       4'h0
`define MWD_CAUSE_FLASH_OUT 4'h5
`define MWD_CAUSE_FLASH_RDY 4'h6
`define MWD_CAUSE_WDOG      4'hB
`define MWD_SEQ_RST       2'h0

// ----------------------------------------------------------------
// Period codes and period tables in ms, entry 0 in the low bits, 0 means off
// ----------------------------------------------------------------
`define MWD_PERIOD_CODES {6'h36, 6'h35, 6'h33, 6'h2D, 6'h24, 6'h1B, 6'h14, 6'h12, 6'h0C, 6'h09}
`define MWD_TAB_NORM  {16'h0050, 16'h0048, 16'h0040, 16'h0038, 16'h0030, \
                       16'h0028, 16'h0020, 16'h0010, 16'h0008, 16'h0004}
`define MWD_TAB_STBY  {16'h0000, 16'h1000, 16'h0800, 16'h0400, 16'h0280, \
                       16'h0140, 16'h00A0, 16'h0050, 16'h0028, 16'h0014}
`define MWD_TAB_FLASH {16'h2000, 16'h1000, 16'h0800, 16'h0400, 16'h0280, \
                       16'h0140, 16'h00A0, 16'h0050, 16'h0028, 16'h0014}
`define MWD_TAB_SLEEP {16'h0000, 16'h2000, 16'h1800, 16'h1000, 16'h0C00, \
                       16'h0800, 16'h0400, 16'h0280, 16'h0140, 16'h00A0}

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MWD_CLK_NS        20
`define MWD_MS_NS         1000000
`define MWD_INIT_MS       256
`define MWD_RST_HOLD_MS   2
`define MWD_SCK_PERIOD_NS 320

`endif

// ### hdl/mwd_pkg.sv
// Types shared by both ends of the mode and watchdog link
package mwd_pkg;

   typedef enum logic [4:0] {
      ST_STARTUP = 5'b00001,
      ST_NORMAL  = 5'b00010,
      ST_STANDBY = 5'b00100,
      ST_SLEEP   = 5'b01000,
      ST_FLASH   = 5'b10000
   } mwd_state_t;

   typedef enum logic [2:0] {
      REQ_UNDEF      = 3'h0,
      REQ_NORMAL     = 3'h1,
      REQ_STANDBY    = 3'h2,
      REQ_INIT_FLASH = 3'h3,
      REQ_SLEEP      = 3'h4,
      REQ_INIT_NORM  = 3'h5,
      REQ_LEAVE_FLSH = 3'h6,
      REQ_FLASH      = 3'h7
   } mwd_req_t;

   typedef enum logic [4:0] {
      HS_IDLE  = 5'b00001,
      HS_SETUP = 5'b00010,
      HS_HIGH  = 5'b00100,
      HS_LOW   = 5'b01000,
      HS_TAIL  = 5'b10000
   } mwd_hstate_t;

endpackage

// ### hdl/mwd_if.sv
// Serial link between the controller end and the device end
`timescale 1ns/1ps
interface mwd_if;
   logic csn_b;
   logic sck;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   wire  sdo_line;

   // Undriven data line reads low
   assign sdo_line = sdo_oe & sdo;

   modport dev  (input csn_b, input sck, input sdi, output sdo, output sdo_oe);
   modport host (output csn_b, output sck, output sdi, input sdo_line);
endinterface

// ### hdl/mwd_dev.sv
// Device end: mode and watchdog register decode, watchdog timer and reset source
// What this block does
// - Controller serves watchdog by repeated mode writes
// - Accepted write loads period, restarts watchdog
// - Mode register writable in every operating mode
// - First write due before initial deadline
// - Illegal period or mode: discard, force reset
// - Bit 13 picks diagnosis or status read-back
// - Bit 12 set means read only
// - Bits 5..3 request operating mode
// - Bit 2 enables software development mode
// - Bit 1 drives global enable pin
// - Controller writes reserved bit 0 as zero
// - Flash only via normal-flash-normal-flash writes
// - Last flash-entry write forces reset, start-up
// - Reset cause confirms completed flash entry
// - Init-flash within initial deadline enters flash
// - Prescaler 00 periods per mode table
// - Prescaler 01 periods are 1.5 times
// - Prescaler 10 periods are 2.5 times; top code turns off in standby and sleep only
// - Two leading bits select register, 00 here
// - Exactly sixteen clocks per frame, else ignored
// - Cause 0110 means ready for flash
`include "mwd_cfg.svh"
`timescale 1ns/1ps
module mwd_dev import mwd_pkg::*; #(
   parameter int TICK_CYC = `MWD_MS_NS / `MWD_CLK_NS,
   parameter int INIT_MS  = `MWD_INIT_MS,
   parameter int RST_MS   = `MWD_RST_HOLD_MS
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Serial link
   mwd_if.dev              link,
   // Straps and read-back sources
   input  wire logic [1:0]  watchdog_prescale_sel,
   input  wire logic [11:0] diag_info,
   // Device outputs
   output logic            system_reset_out_n,
   output logic            global_enable,
   output logic            debug_relax_mode,
   output logic [3:0]      reset_cause_code,
   output mwd_state_t      op_state
);

   localparam logic [59:0]  CODE_LIST = `MWD_PERIOD_CODES;
   localparam logic [159:0] TAB_NORM  = `MWD_TAB_NORM;
   localparam logic [159:0] TAB_STBY  = `MWD_TAB_STBY;
   localparam logic [159:0] TAB_FLASH = `MWD_TAB_FLASH;
   localparam logic [159:0] TAB_SLEEP = `MWD_TAB_SLEEP;

   // ----------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic       csn_prev_q;
   logic       sck_prev_q;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         // Idle pin levels, so no false edge follows reset
         sync1_q    <= 3'h1;
         sync2_q    <= 3'h1;
         csn_prev_q <= 1'b1;
         sck_prev_q <= 1'b0;
      end else begin
         sync1_q    <= {link.sdi, link.sck, link.csn_b};
         sync2_q    <= sync1_q;
         csn_prev_q <= sync2_q[0];
         sck_prev_q <= sync2_q[1];
      end
   end

   wire csn_s    = sync2_q[0];
   wire sdi_s    = sync2_q[2];
   wire csn_fall = csn_prev_q & ~csn_s;
   wire csn_rise = ~csn_prev_q & csn_s;
   wire sck_fall = sck_prev_q & ~sync2_q[1] & ~csn_s;

   // ----------------------------------------------------------------
   // Frame shifter, bit counter and read-back word
   // ----------------------------------------------------------------
   logic [15:0] rx_q;
   logic [15:0] word_q;
   logic [4:0]  nfall_q;
   logic        sdo_q;
   logic [11:0] status_word;
   logic        flash_rdy_q;

   assign status_word = {reset_cause_code, op_state, flash_rdy_q, debug_relax_mode, global_enable};

   always_ff @(posedge clk) begin
      if (!rst_b || csn_fall) begin
         nfall_q <= 5'h00;
         word_q  <= 16'h0000;
      end else if (sck_fall) begin
         rx_q    <= {rx_q[14:0], sdi_s};
         if (nfall_q != 5'h11)
            nfall_q <= nfall_q + 5'h01;                        // Saturates past a 16-clock frame
         if (nfall_q == 5'h02)
            word_q[11:0] <= sdi_s ? diag_info : status_word;
      end
   end

   // Data changes after each sampling edge, so it is stable across the next rising edge
   wire [3:0] out_idx = 4'hF - nfall_q[3:0];
   always_ff @(posedge clk) begin
      if (!rst_b)
         sdo_q <= 1'b0;
      else
         sdo_q <= word_q[out_idx];
   end
   assign link.sdo    = sdo_q;
   assign link.sdo_oe = ~csn_s;

   // ----------------------------------------------------------------
   // Write decode and period lookup
   // ----------------------------------------------------------------
   wire        frame_ok  = csn_rise & (nfall_q == `MWD_FRAME_BITS);
   wire        hit_mode  = frame_ok & (rx_q[`MWD_F_ADDR] == `MWD_ADDR_MODE);
   wire        wr_en     = hit_mode & ~rx_q[`MWD_B_RDONLY];
   wire [5:0]  per_code  = rx_q[`MWD_F_PERIOD];
   wire [2:0]  req       = rx_q[`MWD_F_STATE];

   logic       code_hit;
   logic [3:0] code_idx;
   always_comb begin
      code_hit = 1'b0;
      code_idx = 4'h0;
      for (int i = 0; i < 10; i++) begin
         if (CODE_LIST[i*6 +: 6] == per_code) begin
            code_hit = 1'b1;
            code_idx = i[3:0];
         end
      end
   end

   wire legal = code_hit & (req != REQ_UNDEF);

   logic [15:0] base_ms;
   always_comb begin
      case (req)
         REQ_STANDBY:                base_ms = TAB_STBY[code_idx*16 +: 16];
         REQ_SLEEP:                  base_ms = TAB_SLEEP[code_idx*16 +: 16];
         REQ_FLASH, REQ_INIT_FLASH:  base_ms = TAB_FLASH[code_idx*16 +: 16];
         default:                    base_ms = TAB_NORM[code_idx*16 +: 16];
      endcase
   end

   // Prescaler 11 is not decoded and falls back to the unscaled table
   logic [15:0] period_ms;
   always_comb begin
      case (watchdog_prescale_sel)
         2'h1:    period_ms = base_ms + {1'b0, base_ms[15:1]};
         2'h2:    period_ms = {base_ms[14:0], 1'b0} + {1'b0, base_ms[15:1]};
         default: period_ms = base_ms;
      endcase
   end

   // ----------------------------------------------------------------
   // Mode requests and flash-entry sequence
   // ----------------------------------------------------------------
   logic [1:0]  seq_q;
   logic [1:0]  seq_d;
   mwd_state_t  state_d;
   logic        force_rst;
   logic [3:0]  force_cause;
   logic        wd_expire;
   logic        rst_act_q;

   always_comb begin
      seq_d       = seq_q;
      state_d     = op_state;
      force_rst   = 1'b0;
      force_cause = `MWD_CAUSE_POR;
      if (wd_expire && !debug_relax_mode) begin
         force_rst   = 1'b1;
         force_cause = `MWD_CAUSE_WDOG;
      end else if (wr_en && !legal) begin
         force_rst = 1'b1;
      end else if (wr_en) begin
         seq_d = `MWD_SEQ_RST;
         case (req)
            REQ_NORMAL: begin
               state_d = ST_NORMAL;
               seq_d   = (seq_q == 2'h2) ? 2'h3 : 2'h1;
            end
            REQ_INIT_NORM:
               state_d = ST_NORMAL;
            REQ_STANDBY:
               state_d = ST_STANDBY;
            REQ_SLEEP:
               state_d = ST_SLEEP;
            REQ_INIT_FLASH: begin
               if (flash_rdy_q)
                  state_d = ST_FLASH;
               else
                  force_rst = 1'b1;
            end
            REQ_FLASH: begin
               if (seq_q == 2'h1) begin
                  seq_d = 2'h2;
               end else if (seq_q == 2'h3) begin
                  force_rst   = 1'b1;
                  force_cause = `MWD_CAUSE_FLASH_RDY;
               end else begin
                  force_rst = 1'b1;
               end
            end
            REQ_LEAVE_FLSH: begin
               force_rst   = 1'b1;
               force_cause = (op_state == ST_FLASH) ? `MWD_CAUSE_FLASH_OUT : `MWD_CAUSE_POR;
            end
            default:
               force_rst = 1'b1;
         endcase
      end
   end

   wire accept = wr_en & ~force_rst;

   always_ff @(posedge clk) begin
      if (!rst_b || force_rst) begin
         op_state         <= ST_STARTUP;
         seq_q            <= `MWD_SEQ_RST;
         global_enable    <= 1'b0;
         debug_relax_mode <= 1'b0;
      end else if (accept) begin
         op_state         <= state_d;
         seq_q            <= seq_d;
         global_enable    <= rx_q[`MWD_B_EN];
         debug_relax_mode <= rx_q[`MWD_B_RELAX];
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         reset_cause_code <= `MWD_CAUSE_POR;
         flash_rdy_q      <= 1'b0;
      end else if (force_rst) begin
         reset_cause_code <= force_cause;
         flash_rdy_q      <= (force_cause == `MWD_CAUSE_FLASH_RDY);
      end else if (accept) begin
         flash_rdy_q      <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Millisecond tick, reset pulse and watchdog timer
   // ----------------------------------------------------------------
   logic [31:0] tick_q;
   wire         tick = (tick_q == 32'(TICK_CYC - 1));

   always_ff @(posedge clk) begin
      // Restarts on a service write, so no partial first tick shortens the period
      if (!rst_b || tick || accept)
         tick_q <= 32'h0000_0000;
      else
         tick_q <= tick_q + 32'h0000_0001;
   end

   logic [15:0] rst_cnt_q;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rst_act_q <= 1'b0;
         rst_cnt_q <= 16'h0000;
      end else if (force_rst) begin
         rst_act_q <= 1'b1;
         rst_cnt_q <= 16'(RST_MS);
      end else if (rst_act_q && tick) begin
         rst_cnt_q <= rst_cnt_q - 16'h0001;
         if (rst_cnt_q == 16'h0001)
            rst_act_q <= 1'b0;
      end
   end
   assign system_reset_out_n = ~rst_act_q;

   // Timer restarts from the service write; a zero period means the watchdog is off
   logic [15:0] wd_cnt_q;
   logic [15:0] period_q;
   logic        wd_on_q;
   logic        wd_arm_q;
   assign wd_expire = wd_on_q & tick & (wd_cnt_q == 16'h0001) & ~rst_act_q;

   always_ff @(posedge clk) begin
      if (!rst_b || force_rst) begin
         wd_on_q  <= 1'b0;
         wd_arm_q <= 1'b1;
         wd_cnt_q <= 16'h0000;
         period_q <= 16'h0000;
      end else if (accept) begin
         wd_on_q  <= (period_ms != 16'h0000);
         wd_arm_q <= 1'b0;
         wd_cnt_q <= period_ms;
         period_q <= period_ms;
      end else if (rst_act_q) begin
         wd_cnt_q <= 16'h0000;
      end else if (wd_arm_q) begin
         wd_on_q  <= 1'b1;
         wd_arm_q <= 1'b0;
         wd_cnt_q <= 16'(INIT_MS);
         period_q <= 16'(INIT_MS);
      end else if (wd_on_q && tick) begin
         wd_cnt_q <= (wd_cnt_q == 16'h0001) ? period_q : wd_cnt_q - 16'h0001;
      end
   end

endmodule

// ### hdl/mwd_host.sv
// Controller end: sends one 16-bit frame per request and returns the read-back word
`include "mwd_cfg.svh"
`timescale 1ns/1ps
module mwd_host import mwd_pkg::*; #(
   parameter int HALF = `MWD_SCK_PERIOD_NS / (2 * `MWD_CLK_NS)
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Serial link
   mwd_if.host              link,
   // User side
   input  wire logic        start,
   input  wire logic [15:0] tx_word,
   output logic             busy,
   output logic [15:0]      rx_word,
   output logic             done
);

   // ----------------------------------------------------------------
   // Read-back synchroniser
   // ----------------------------------------------------------------
   logic sdo1_q;
   logic sdo2_q;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         sdo1_q <= 1'b0;
         sdo2_q <= 1'b0;
      end else begin
         sdo1_q <= link.sdo_line;
         sdo2_q <= sdo1_q;
      end
   end

   // ----------------------------------------------------------------
   // Frame sequencer
   // ----------------------------------------------------------------
   mwd_hstate_t st_q;
   logic [7:0]  div_q;
   logic [3:0]  bit_q;
   logic [15:0] sh_q;
   logic        csn_q;
   logic        sck_q;
   logic        sdi_q;
   logic        gap_q;

   wire half_end = (div_q == 8'(HALF - 1));
   wire rise     = half_end & ((st_q == HS_SETUP) | (st_q == HS_LOW));

   always_ff @(posedge clk) begin
      if (!rst_b || st_q == HS_IDLE || half_end)
         div_q <= 8'h00;
      else
         div_q <= div_q + 8'h01;
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_q  <= HS_IDLE;
         csn_q <= 1'b1;
         sck_q <= 1'b0;
         sdi_q <= 1'b0;
         bit_q <= 4'h0;
         gap_q <= 1'b0;
         sh_q  <= 16'h0000;
      end else begin
         case (st_q)
            HS_IDLE: begin
               if (start) begin
                  // Address bits lead, reserved bit always sent clear
                  sh_q  <= {tx_word[15:1], 1'b0};
                  csn_q <= 1'b0;
                  bit_q <= 4'h0;
                  st_q  <= HS_SETUP;
               end
            end
            HS_SETUP, HS_LOW: begin
               if (half_end) begin
                  sck_q <= 1'b1;
                  sdi_q <= sh_q[15];
                  sh_q  <= {sh_q[14:0], 1'b0};
                  st_q  <= HS_HIGH;
               end
            end
            HS_HIGH: begin
               if (half_end) begin
                  sck_q <= 1'b0;
                  bit_q <= bit_q + 4'h1;
                  st_q  <= (bit_q == 4'hF) ? HS_TAIL : HS_LOW;
               end
            end
            HS_TAIL: begin
               if (half_end) begin
                  csn_q <= 1'b1;
                  gap_q <= ~gap_q;
                  // One idle half period between frames keeps them apart
                  if (gap_q)
                     st_q <= HS_IDLE;
               end
            end
            default:
               st_q <= HS_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read-back capture and user handshake
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b)
         rx_word <= 16'h0000;
      else if (rise)
         rx_word <= {rx_word[14:0], sdo2_q};
   end

   // Serving is repeated by issuing frames; pacing against the deadlines is the user's task
   assign busy = (st_q != HS_IDLE);
   assign done = (st_q == HS_TAIL) & half_end & gap_q;

   assign link.csn_b = csn_q;
   assign link.sck   = sck_q;
   assign link.sdi   = sdi_q;

endmodule

// ### verification/mwd_link_props.sv
// Assertions on the serial link between controller end and device end
`timescale 1ns/1ps
module mwd_link_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Link signals
   input wire logic csn_b,
   input wire logic sck,
   input wire logic sdi,
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic sdo_line
);
   // ----------------------------------------------------------------
   // Falling clock edges seen in the current frame
   // ----------------------------------------------------------------
   logic       sck_q;
   logic [4:0] falls_q;
   logic [4:0] falls_d;

   assign falls_d = (sck_q && !sck) ? falls_q + 5'h1 : falls_q;

   always_ff @(posedge clk) begin
      sck_q   <= sck;
      falls_q <= (!rst_b || csn_b) ? 5'h00 : falls_d;
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_sck_idle; csn_b |-> !sck; endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("clock moves outside frame");
   property p_sck_high; $rose(sck) |=> sck [*7]; endproperty
   a_sck_high: assert property (p_sck_high) else $error("clock high too short");
   property p_sck_low; $fell(sck) |=> !sck [*7]; endproperty
   a_sck_low: assert property (p_sck_low) else $error("clock low too short");
   property p_count16; $rose(csn_b) |-> falls_q == 5'h10; endproperty
   a_count16: assert property (p_count16) else $error("frame not sixteen clocks");
   property p_csn_gap; $rose(csn_b) |=> csn_b [*3]; endproperty
   a_csn_gap: assert property (p_csn_gap) else $error("frames too close");
   property p_oe_on; $fell(csn_b) |-> ##[1:5] sdo_oe; endproperty
   a_oe_on: assert property (p_oe_on) else $error("data line not driven");
   property p_oe_off; $rose(csn_b) |-> ##[1:5] !sdo_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("data line not released");
   property p_sdi_hold; $fell(sck) |-> $stable(sdi); endproperty
   a_sdi_hold: assert property (p_sdi_hold) else $error("data moved at sample edge");
   property p_top_zero; $rose(sck) && falls_q < 5'h4 |-> !sdo_line; endproperty
   a_top_zero: assert property (p_top_zero) else $error("read-back header not zero");
   property p_sdo_setup; $rose(sck) && sdo_oe |-> $stable(sdo); endproperty
   a_sdo_setup: assert property (p_sdo_setup) else $error("read-back moved at host sample");
endmodule

// ### verification/mode_watchdog_register_tb.sv
// Self-checking bench for both ends of the mode and watchdog link
`timescale 1ns/1ps
`include "mwd_cfg.svh"
module mode_watchdog_register_tb import mwd_pkg::*; ;
   // Short tick keeps the watchdog runs brief
   localparam int          TICK  = 500;
   localparam logic [59:0] CODES = `MWD_PERIOD_CODES;
   logic        clk, rst_b, start, busy, done, sys_rst_n, en, relax;
   logic [1:0]  pre;
   logic [11:0] diag;
   logic [15:0] tx, rx, got, b;
   logic [5:0]  c;
   logic [3:0]  cause;
   mwd_state_t  st;
   int          errors, n_checks, seed, n, t, k, p;
   int          per[3] = '{4, 6, 10};

   mwd_if link_i ();
   mwd_dev #(.TICK_CYC(TICK), .INIT_MS(20), .RST_MS(2)) mwd_dev_i (.clk(clk), .rst_b(rst_b), .link(link_i.dev),
      .watchdog_prescale_sel(pre), .diag_info(diag), .system_reset_out_n(sys_rst_n), .global_enable(en),
      .debug_relax_mode(relax), .reset_cause_code(cause), .op_state(st));
   mwd_host mwd_host_i (.clk(clk), .rst_b(rst_b), .link(link_i.host), .start(start), .tx_word(tx), .busy(busy),
      .rx_word(rx), .done(done));
   mwd_link_props mwd_link_props_i (.clk(clk), .rst_b(rst_b), .csn_b(link_i.csn_b), .sck(link_i.sck),
      .sdi(link_i.sdi), .sdo(link_i.sdo), .sdo_oe(link_i.sdo_oe), .sdo_line(link_i.sdo_line));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic finish_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   function automatic logic [15:0] fr(input logic rd_only, page, input logic [5:0] cd, input logic [2:0] md,
                                      input logic s, e);
      return {2'b00, page, rd_only, cd, md, s, e, 1'b0};
   endfunction
   task automatic chk_st(input logic e, r, input logic [3:0] cc, input mwd_state_t s);
      chk({4'h0, en, relax, sys_rst_n, cause, st}, {4'h0, e, r, 1'b1, cc, s});
   endtask
   task automatic wait_for(input logic lvl, input int lim);
      n = 0;
      while (sys_rst_n !== lvl && n < lim) begin
         @(posedge clk);
         #1;
         n++;
      end
   endtask
   // One frame; done is a one-cycle pulse, so look once per cycle
   task automatic send(input logic [15:0] w);
      @(posedge clk);
      #1;
      start = 1'b1;
      tx = w;
      @(posedge clk);
      #1;
      start = 1'b0;
      chk({15'h0000, busy}, 16'h0001);
      n = 0;
      while (done !== 1'b1 && n < 2000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({15'h0000, done}, 16'h0001);
      got = rx;
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic expect_rst(input logic [3:0] cc, input int lim);
      wait_for(1'b0, lim);
      t = n;
      chk({15'h0000, sys_rst_n}, 16'h0000);
      wait_for(1'b1, 3000);
      chk({5'h00, en, sys_rst_n, cause, st}, {5'h00, 1'b0, 1'b1, cc, ST_STARTUP});
   endtask
   task automatic flash_seq(input logic [2:0] m3, input logic [3:0] cc);
      send(fr(1'b0, 1'b0, 6'h36, REQ_NORMAL, 1'b0, 1'b1));
      send(fr(1'b0, 1'b0, 6'h36, REQ_FLASH, 1'b0, 1'b1));
      send(fr(1'b0, 1'b0, 6'h36, m3, 1'b0, 1'b1));
      send(fr(1'b0, 1'b0, 6'h36, REQ_FLASH, 1'b0, 1'b1));
      expect_rst(cc, 40);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      seed = 32'hC04249E6;
      errors = 0;
      n_checks = 0;
      rst_b = 1'b0;
      start = 1'b0;
      tx = 16'h0000;
      pre = 2'h0;
      diag = 12'h000;
      repeat (12) @(posedge clk);
      #1;
      rst_b = 1'b1;
      chk_st(1'b0, 1'b0, 4'h0, ST_STARTUP);
      diag = 12'($random(seed));
      send(fr(1'b1, 1'b1, 6'h00, 3'h0, 1'b1, 1'b1));
      chk(got, {4'h0, diag});
      send(fr(1'b1, 1'b0, 6'h00, 3'h0, 1'b1, 1'b1));
      chk(got & 16'hFFFB, {8'h00, ST_STARTUP, 3'h0});
      k = {$random(seed)} % 10;
      b = 16'($random(seed));
      send(fr(1'b0, 1'b0, CODES[6*k +: 6], REQ_NORMAL, b[1], b[0]));
      chk_st(b[0], b[1], 4'h0, ST_NORMAL);
      send(fr(1'b1, 1'b0, 6'h00, 3'h0, 1'b0, 1'b0));
      chk(got & 16'hFFFB, {8'h00, ST_NORMAL, 1'b0, b[1], b[0]});
      send(fr(1'b0, 1'b0, CODES[6*k +: 6], REQ_STANDBY, ~b[1], ~b[0]) | 16'h4000);
      chk_st(b[0], b[1], 4'h0, ST_NORMAL);
      for (p = 0; p < 3; p++) begin
         pre = 2'(p);
         send(fr(1'b0, 1'b0, 6'h09, REQ_NORMAL, 1'b0, 1'b1));
         repeat (per[p] * TICK * 7 / 10) @(posedge clk);
         send(fr(1'b0, 1'b0, 6'h09, REQ_NORMAL, 1'b0, 1'b1));
         expect_rst(4'hB, 20000);
         chk({15'h0000, t > per[p] * TICK - TICK && t < per[p] * TICK + TICK}, 16'h0001);
      end
      send(fr(1'b0, 1'b0, 6'h09, 3'h0, 1'b0, 1'b1));
      expect_rst(4'h0, 40);
      c = 6'h09;
      while (CODES[59:54] == c || CODES[53:48] == c || CODES[47:42] == c || CODES[41:36] == c ||
             CODES[35:30] == c || CODES[29:24] == c || CODES[23:18] == c || CODES[17:12] == c ||
             CODES[11:6] == c || CODES[5:0] == c) c = 6'($random(seed));
      send(fr(1'b0, 1'b0, c, REQ_NORMAL, 1'b0, 1'b1));
      expect_rst(4'h0, 40);
      flash_seq(REQ_STANDBY, 4'h0);
      flash_seq(REQ_NORMAL, 4'h6);
      send(fr(1'b1, 1'b0, 6'h00, 3'h0, 1'b0, 1'b0));
      chk(got, {8'h06, ST_STARTUP, 3'h4});
      send(fr(1'b0, 1'b0, 6'h36, REQ_INIT_FLASH, 1'b0, 1'b0));
      chk({11'h000, st}, {11'h000, ST_FLASH});
      send(fr(1'b0, 1'b0, 6'h36, REQ_LEAVE_FLSH, 1'b0, 1'b0));
      expect_rst(4'h5, 40);
      // Top code in sleep turns the watchdog off, so no reset past the first deadline
      send(fr(1'b0, 1'b0, 6'h36, REQ_SLEEP, 1'b0, 1'b0));
      chk({11'h000, st}, {11'h000, ST_SLEEP});
      wait_for(1'b0, 11000);
      chk({15'h0000, sys_rst_n}, 16'h0001);
      send(fr(1'b0, 1'b0, 6'h09, REQ_INIT_NORM, 1'b0, 1'b1));
      chk_st(1'b1, 1'b0, 4'h5, ST_NORMAL);
      finish_test();
   end

   // Whole run needs about 43000 cycles
   initial begin
      #(1_500_000);
      errors++;
      finish_test();
   end
endmodule
